// >>> pkg/mib_regs.svh
// register offsets, field positions, codes and timing counts of the maintenance/ident bank
// assumes a 16-bit word-addressed register port and a 100 MHz system clock
`ifndef MIB_REGS_SVH
`define MIB_REGS_SVH

// ----------------------------------------------------------------
// word offsets
// ----------------------------------------------------------------
`define MIB_OFS_PROCESS_VALUE 16'h0027
`define MIB_OFS_PROCESS_MINIMUM 16'h002A
`define MIB_OFS_PROCESS_MAXIMUM 16'h002B
`define MIB_OFS_MINIMUM_CLEAR 16'h0041
`define MIB_OFS_MAXIMUM_CLEAR 16'h0042
`define MIB_OFS_CONFIG_MODE_COMMAND 16'h0100
`define MIB_OFS_PANEL_CHANGE_FLAG 16'h0101
`define MIB_OFS_ORDER_CODE_TEXT 16'h0168
`define MIB_OFS_IDENT_NUMBER_HIGH 16'h0172
`define MIB_OFS_IDENT_NUMBER_LOW 16'h0173
`define MIB_OFS_IDENT_SERIAL 16'h0174
`define MIB_OFS_OEM_NUMBER_HIGH 16'h0175
`define MIB_OFS_OEM_NUMBER_LOW 16'h0176
`define MIB_OFS_SOFTWARE_ORDER_DIGITS 16'h0177
`define MIB_OFS_PEAK_TEMPERATURE 16'h017C
`define MIB_OFS_NVM_LAYOUT_VERSION 16'h017D
`define MIB_OFS_DIAGNOSIS_RESULT 16'h017E
`define MIB_OFS_TOTAL_RUN_HOURS 16'h0186
`define MIB_OFS_TOTAL_CYCLES_OUT_ONE 16'h0187
`define MIB_OFS_TOTAL_CYCLES_OUT_TWO 16'h0188
`define MIB_OFS_PERIOD_RUN_HOURS 16'h018A
`define MIB_OFS_PERIOD_CYCLES_OUT_ONE 16'h018B
`define MIB_OFS_PERIOD_CYCLES_OUT_TWO 16'h018C

// ----------------------------------------------------------------
// command codes and fields
// ----------------------------------------------------------------
`define MIB_CFG_END 16'h0000
`define MIB_CFG_START 16'h0001
`define MIB_CFG_ABORT 16'h0002
`define MIB_DIAG_SELFTEST_LSB 0
`define MIB_DIAG_HOURS_BIT 4
`define MIB_DIAG_CYCLES_BIT 5
`define MIB_FLAG_BIT 0

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define MIB_RST_WORD 16'h0000
`define MIB_RST_LONG 32'h0000_0000
`define MIB_RST_TEMP 16'h8000
`define MIB_HOUR_S 3600
`define MIB_CLK_HZ 100000000
`define MIB_HOUR_CYCLES (64'(`MIB_HOUR_S) * 64'(`MIB_CLK_HZ))

`endif

// >>> pkg/mib_pkg.sv
// types shared by the maintenance/ident register bank
// assumes nothing beyond a SystemVerilog elaborator
`default_nettype none

package mib_pkg;
	typedef enum logic {MIB_CFG_RUN, MIB_CFG_EDIT} mib_cfg_state_type;
	typedef logic [31:0] mib_long_type;
endpackage : mib_pkg

`default_nettype wire

// >>> logic/mib_register_bank.sv
// maintenance, diagnosis and identity register bank behind a word-addressed register port
// assumes process value, temperature, faults and acks come from logic on sys_clk,
// while output_one/output_two are pins and are synchronised here
`default_nettype none
`include "mib_regs.svh"

module mib_register_bank #(
	parameter logic [63:0] HOUR_CYCLES = `MIB_HOUR_CYCLES,
	parameter logic [31:0] PERIOD_HOURS_LIMIT = 32'h0000_2710,
	parameter logic [31:0] PERIOD_CYCLES_LIMIT = 32'h000F_4240,
	parameter logic [15:0] IDENT_HIGH = 16'h1234, // arbitrary value
	parameter logic [15:0] IDENT_LOW = 16'h5678, // arbitrary value
	parameter logic [15:0] IDENT_SERIAL = 16'h0001, // arbitrary value
	parameter logic [15:0] OEM_HIGH = 16'h0000, // arbitrary value
	parameter logic [15:0] OEM_LOW = 16'h0000, // arbitrary value
	parameter logic [15:0] SW_DIGITS = 16'h1234, // arbitrary value
	parameter logic [15:0] NVM_VERSION = 16'h0001, // arbitrary value
	parameter logic [119:0] ORDER_TEXT = "ORDER-0000-0000" // arbitrary value
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [15:0] reg_addr,
	input wire logic [2:0] reg_sub,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata_ff,
	output logic reg_ack_ff,
	input wire logic [31:0] process_value_in,
	input wire logic process_valid,
	input wire logic [15:0] temp_sample,
	input wire logic temp_valid,
	input wire logic [3:0] selftest_fault,
	input wire logic diag_ack,
	input wire logic hours_limit_ack,
	input wire logic cycles_limit_ack,
	input wire logic panel_edit,
	input wire logic output_one,
	input wire logic output_two,
	output logic config_active_ff,
	output logic config_apply_ff,
	output logic config_abort_ff,
	output logic panel_change_flag_ff
);

	// ----------------------------------------------------------------
	// register port decode
	// ----------------------------------------------------------------
	wire logic wr_cfg = reg_wr && (reg_addr == `MIB_OFS_CONFIG_MODE_COMMAND);
	wire logic wr_flag = reg_wr && (reg_addr == `MIB_OFS_PANEL_CHANGE_FLAG);
	wire logic wr_min_clr = reg_wr && (reg_addr == `MIB_OFS_MINIMUM_CLEAR) && reg_wdata[0];
	wire logic wr_max_clr = reg_wr && (reg_addr == `MIB_OFS_MAXIMUM_CLEAR) && reg_wdata[0];
	wire logic [1:0] wr_per_cyc;
	assign wr_per_cyc[0] = reg_wr && (reg_addr == `MIB_OFS_PERIOD_CYCLES_OUT_ONE);
	assign wr_per_cyc[1] = reg_wr && (reg_addr == `MIB_OFS_PERIOD_CYCLES_OUT_TWO);

	// ----------------------------------------------------------------
	// configuration mode
	// ----------------------------------------------------------------
	mib_pkg::mib_cfg_state_type cfg_state_ff;
	mib_pkg::mib_cfg_state_type nxt_cfg_state;
	logic [15:0] cfg_code_ff;
	wire logic cfg_legal = (reg_wdata == `MIB_CFG_END) || (reg_wdata == `MIB_CFG_START)
		|| (reg_wdata == `MIB_CFG_ABORT);
	wire logic cfg_take = wr_cfg && cfg_legal;
	wire logic cfg_apply = cfg_take && (reg_wdata == `MIB_CFG_END)
		&& (cfg_state_ff == mib_pkg::MIB_CFG_EDIT);
	wire logic cfg_abort = cfg_take && (reg_wdata == `MIB_CFG_ABORT)
		&& (cfg_state_ff == mib_pkg::MIB_CFG_EDIT);

	always_comb begin
		nxt_cfg_state = cfg_state_ff;
		unique case (cfg_state_ff)
			mib_pkg::MIB_CFG_RUN: begin
				if (cfg_take && (reg_wdata == `MIB_CFG_START))
					nxt_cfg_state = mib_pkg::MIB_CFG_EDIT;
			end
			mib_pkg::MIB_CFG_EDIT: begin
				if (cfg_apply || cfg_abort)
					nxt_cfg_state = mib_pkg::MIB_CFG_RUN;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_state_ff <= mib_pkg::MIB_CFG_RUN;
			cfg_code_ff <= `MIB_CFG_END;
			config_active_ff <= 1'b0;
			config_apply_ff <= 1'b0;
			config_abort_ff <= 1'b0;
		end else begin
			cfg_state_ff <= nxt_cfg_state;
			cfg_code_ff <= cfg_take ? reg_wdata : cfg_code_ff;
			config_active_ff <= (nxt_cfg_state == mib_pkg::MIB_CFG_EDIT);
			config_apply_ff <= cfg_apply;
			config_abort_ff <= cfg_abort;
		end
	end

	// ----------------------------------------------------------------
	// front-panel change flag
	// ----------------------------------------------------------------
	// a panel edit in the same cycle as a master write wins, so no edit is lost
	wire logic nxt_panel_flag = panel_edit
		|| (wr_flag ? reg_wdata[`MIB_FLAG_BIT] : panel_change_flag_ff);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			panel_change_flag_ff <= 1'b0;
		else
			panel_change_flag_ff <= nxt_panel_flag;
	end

	// ----------------------------------------------------------------
	// process value and min/max tracking
	// ----------------------------------------------------------------
	logic [31:0] pv_ff;
	logic [31:0] min_ff;
	logic [31:0] max_ff;
	wire logic min_lower = $signed(process_value_in) < $signed(min_ff);
	wire logic max_higher = $signed(process_value_in) > $signed(max_ff);
	wire logic [31:0] nxt_min = (process_valid && (min_lower || wr_min_clr)) ? process_value_in
		: (wr_min_clr ? pv_ff : min_ff);
	wire logic [31:0] nxt_max = (process_valid && (max_higher || wr_max_clr)) ? process_value_in
		: (wr_max_clr ? pv_ff : max_ff);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pv_ff <= `MIB_RST_LONG;
			min_ff <= `MIB_RST_LONG;
			max_ff <= `MIB_RST_LONG;
		end else begin
			pv_ff <= process_valid ? process_value_in : pv_ff;
			min_ff <= nxt_min;
			max_ff <= nxt_max;
		end
	end

	// ----------------------------------------------------------------
	// peak temperature
	// ----------------------------------------------------------------
	logic [15:0] peak_temp_ff;
	wire logic temp_higher = temp_valid && ($signed(temp_sample) > $signed(peak_temp_ff));

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			peak_temp_ff <= `MIB_RST_TEMP;
		else
			peak_temp_ff <= temp_higher ? temp_sample : peak_temp_ff;
	end

	// ----------------------------------------------------------------
	// hour timebase and hour counters
	// ----------------------------------------------------------------
	logic [63:0] hour_cnt_ff;
	logic [31:0] total_hours_ff;
	logic [31:0] period_hours_ff;
	wire logic hour_tick = (hour_cnt_ff == (HOUR_CYCLES - 64'h1));
	// an hour that ends on the acknowledge cycle is counted into the new period
	wire logic [31:0] nxt_period_hours = hours_limit_ack ? {31'h0, hour_tick}
		: period_hours_ff + {31'h0, hour_tick};

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			hour_cnt_ff <= 64'h0;
			total_hours_ff <= `MIB_RST_LONG;
			period_hours_ff <= `MIB_RST_LONG;
		end else begin
			hour_cnt_ff <= hour_tick ? 64'h0 : hour_cnt_ff + 64'h1;
			total_hours_ff <= total_hours_ff + {31'h0, hour_tick};
			period_hours_ff <= nxt_period_hours;
		end
	end

	// ----------------------------------------------------------------
	// switching-cycle counters, one set per output
	// ----------------------------------------------------------------
	wire logic [1:0] out_pins = {output_two, output_one};
	logic [31:0] tot_live_ff [2];
	logic [31:0] tot_vis_ff [2];
	logic [31:0] per_live_ff [2];
	logic [31:0] per_vis_ff [2];
	wire logic [1:0] per_over;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_out
			logic sync1_ff;
			logic sync2_ff;
			logic prev_ff;
			wire logic rise = sync2_ff && !prev_ff;
			wire logic per_clr = cycles_limit_ack || wr_per_cyc[gi];
			wire logic [31:0] nxt_per = per_clr ? {31'h0, rise}
				: per_live_ff[gi] + {31'h0, rise};
			// a count being cleared this cycle no longer raises the limit bit,
			// otherwise the acknowledge could never clear its own diagnosis bit
			assign per_over[gi] = (per_live_ff[gi] >= PERIOD_CYCLES_LIMIT) && !per_clr;

			always_ff @(posedge sys_clk or negedge reset_n) begin
				if (!reset_n) begin
					sync1_ff <= 1'b0;
					sync2_ff <= 1'b0;
					prev_ff <= 1'b0;
					tot_live_ff[gi] <= `MIB_RST_LONG;
					tot_vis_ff[gi] <= `MIB_RST_LONG;
					per_live_ff[gi] <= `MIB_RST_LONG;
					per_vis_ff[gi] <= `MIB_RST_LONG;
				end else begin
					sync1_ff <= out_pins[gi];
					sync2_ff <= sync1_ff;
					prev_ff <= sync2_ff;
					tot_live_ff[gi] <= tot_live_ff[gi] + {31'h0, rise};
					tot_vis_ff[gi] <= hour_tick ? tot_live_ff[gi] : tot_vis_ff[gi];
					per_live_ff[gi] <= nxt_per;
					per_vis_ff[gi] <= per_clr ? `MIB_RST_LONG
						: (hour_tick ? per_live_ff[gi] : per_vis_ff[gi]);
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// diagnosis result
	// ----------------------------------------------------------------
	logic [15:0] diag_ff;
	wire logic hours_over = (period_hours_ff >= PERIOD_HOURS_LIMIT) && !hours_limit_ack;
	wire logic [15:0] diag_set = {10'h0, |per_over, hours_over, selftest_fault};
	wire logic [15:0] diag_clr = {10'h0, cycles_limit_ack, hours_limit_ack, {4{diag_ack}}};
	// a fault raised on the acknowledge cycle survives it
	wire logic [15:0] nxt_diag = (diag_ff & ~diag_clr) | diag_set;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			diag_ff <= `MIB_RST_WORD;
		else
			diag_ff <= nxt_diag;
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	logic [31:0] snap_ff;
	logic [31:0] wide_val;
	logic wide_hit;
	logic [15:0] narrow_val;
	wire logic [127:0] order_pad = {ORDER_TEXT, 8'h00};
	wire logic [127:0] order_shift = order_pad >> {(3'h7 - reg_sub), 4'h0};
	wire logic [15:0] order_word = order_shift[15:0];

	always_comb begin
		wide_hit = 1'b1;
		unique case (reg_addr)
			`MIB_OFS_PROCESS_VALUE: wide_val = pv_ff;
			`MIB_OFS_PROCESS_MINIMUM: wide_val = min_ff;
			`MIB_OFS_PROCESS_MAXIMUM: wide_val = max_ff;
			`MIB_OFS_TOTAL_RUN_HOURS: wide_val = total_hours_ff;
			`MIB_OFS_TOTAL_CYCLES_OUT_ONE: wide_val = tot_vis_ff[0];
			`MIB_OFS_TOTAL_CYCLES_OUT_TWO: wide_val = tot_vis_ff[1];
			`MIB_OFS_PERIOD_RUN_HOURS: wide_val = period_hours_ff;
			`MIB_OFS_PERIOD_CYCLES_OUT_ONE: wide_val = per_vis_ff[0];
			`MIB_OFS_PERIOD_CYCLES_OUT_TWO: wide_val = per_vis_ff[1];
			default: begin
				wide_val = `MIB_RST_LONG;
				wide_hit = 1'b0;
			end
		endcase
	end

	always_comb begin
		unique case (reg_addr)
			`MIB_OFS_CONFIG_MODE_COMMAND: narrow_val = cfg_code_ff;
			`MIB_OFS_PANEL_CHANGE_FLAG: narrow_val = {15'h0, panel_change_flag_ff};
			`MIB_OFS_ORDER_CODE_TEXT: narrow_val = order_word;
			`MIB_OFS_IDENT_NUMBER_HIGH: narrow_val = IDENT_HIGH;
			`MIB_OFS_IDENT_NUMBER_LOW: narrow_val = IDENT_LOW;
			`MIB_OFS_IDENT_SERIAL: narrow_val = IDENT_SERIAL;
			`MIB_OFS_OEM_NUMBER_HIGH: narrow_val = OEM_HIGH;
			`MIB_OFS_OEM_NUMBER_LOW: narrow_val = OEM_LOW;
			`MIB_OFS_SOFTWARE_ORDER_DIGITS: narrow_val = SW_DIGITS;
			`MIB_OFS_PEAK_TEMPERATURE: narrow_val = peak_temp_ff;
			`MIB_OFS_NVM_LAYOUT_VERSION: narrow_val = NVM_VERSION;
			`MIB_OFS_DIAGNOSIS_RESULT: narrow_val = diag_ff;
			default: narrow_val = `MIB_RST_WORD;
		endcase
	end

	// sub-word 0 returns the high half and freezes the whole value, so the low half
	// read next belongs to the same sample even if the counter moved in between
	wire logic snap_take = reg_rd && wide_hit && (reg_sub == 3'h0);
	wire logic [15:0] rd_word = !wide_hit ? narrow_val
		: ((reg_sub == 3'h0) ? wide_val[31:16] : snap_ff[15:0]);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			snap_ff <= `MIB_RST_LONG;
			reg_rdata_ff <= `MIB_RST_WORD;
			reg_ack_ff <= 1'b0;
		end else begin
			snap_ff <= snap_take ? wide_val : snap_ff;
			reg_rdata_ff <= reg_rd ? rd_word : reg_rdata_ff;
			reg_ack_ff <= reg_rd || reg_wr;
		end
	end

endmodule : mib_register_bank

`default_nettype wire

// >>> testbench/mib_register_bank_asserts.sv
// port-level checker for the maintenance/ident register bank
// assumes it is bound onto mib_register_bank, one clock, async active-low reset
`default_nettype none

// ----------------------------------------------------------------
// checker
// ----------------------------------------------------------------
module mib_register_bank_asserts (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_ack_ff,
	input wire logic panel_edit,
	input wire logic config_active_ff,
	input wire logic config_apply_ff,
	input wire logic config_abort_ff,
	input wire logic panel_change_flag_ff
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	wire cw = reg_wr && reg_addr == 16'h0100;
	property p_ack;
		(reg_rd || reg_wr) |=> reg_ack_ff;
	endproperty
	a_ack : assert property (p_ack)
		else $error("access not acknowledged next cycle");
	property p_noack;
		!(reg_rd || reg_wr) |=> !reg_ack_ff;
	endproperty
	a_noack : assert property (p_noack)
		else $error("acknowledge without access");
	property p_start;
		cw && reg_wdata == 16'h0001 |=> config_active_ff;
	endproperty
	a_start : assert property (p_start)
		else $error("start code did not enter configuration");
	property p_end;
		cw && reg_wdata == 16'h0000 && config_active_ff |=> config_apply_ff && !config_active_ff;
	endproperty
	a_end : assert property (p_end)
		else $error("end code did not apply and leave");
	property p_abort;
		cw && reg_wdata == 16'h0002 && config_active_ff |=> config_abort_ff && !config_apply_ff;
	endproperty
	a_abort : assert property (p_abort)
		else $error("abort code did not abandon");
	property p_refuse;
		cw && reg_wdata > 16'h0002 |=> $stable(config_active_ff) && !config_apply_ff;
	endproperty
	a_refuse : assert property (p_refuse)
		else $error("illegal code changed configuration");
	property p_apply_once;
		config_apply_ff |-> $past(config_active_ff) ##1 !config_apply_ff;
	endproperty
	a_apply_once : assert property (p_apply_once)
		else $error("apply pulse malformed");
	property p_edit;
		panel_edit |=> panel_change_flag_ff;
	endproperty
	a_edit : assert property (p_edit)
		else $error("panel edit did not set flag");
	property p_hold;
		panel_change_flag_ff && !(reg_wr && reg_addr == 16'h0101) |=> panel_change_flag_ff;
	endproperty
	a_hold : assert property (p_hold)
		else $error("panel flag dropped without write");
endmodule : mib_register_bank_asserts

bind mib_register_bank mib_register_bank_asserts u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
	.reg_ack_ff(reg_ack_ff), .panel_edit(panel_edit), .config_active_ff(config_active_ff),
	.config_apply_ff(config_apply_ff), .config_abort_ff(config_abort_ff),
	.panel_change_flag_ff(panel_change_flag_ff));

`default_nettype wire

// >>> testbench/mib_field_master.sv
// field-bus master model issuing single-word register accesses
// assumes the bank acks exactly once per one-cycle strobe
`default_nettype none

module mib_field_master (
	input wire logic sys_clk,
	output logic [15:0] reg_addr,
	output logic [2:0] reg_sub,
	output logic reg_rd,
	output logic reg_wr,
	output logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata_ff,
	input wire logic reg_ack_ff
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		reg_addr = 16'h0000;
		reg_sub = 3'h0;
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_wdata = 16'h0000;
	end
	// strobe is one cycle wide; address and data stay until the ack edge
	task automatic xfer(input logic w, input logic [15:0] a, input logic [2:0] s,
		input logic [15:0] d, output logic [15:0] q);
		int n = 0;
		@(posedge sys_clk);
		reg_addr <= a;
		reg_sub <= s;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (reg_ack_ff !== 1'b1 && n < 8);
		q = (reg_ack_ff === 1'b1) ? reg_rdata_ff : 16'hXXXX;
		// released lines must not keep looking valid
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : xfer
endmodule : mib_field_master

`default_nettype wire

// >>> testbench/test_maintenance_ident_register_bank.sv
// self-checking bench for the maintenance/ident register bank
// assumes the bank, its checker and the field master model are compiled before it
`default_nettype none

module test_maintenance_ident_register_bank;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] ID_H = 16'h1A2B; // arbitrary value
	localparam logic [15:0] ID_L = 16'h3C4D; // arbitrary value
	localparam logic [15:0] ID_S = 16'h0042; // arbitrary value
	localparam logic [15:0] OEM_H = 16'h5E6F; // arbitrary value
	localparam logic [15:0] OEM_L = 16'h7081; // arbitrary value
	localparam logic [15:0] SW_D = 16'h0912; // arbitrary value
	localparam logic [15:0] NVM = 16'h0003; // arbitrary value
	localparam logic [119:0] TXT = "TESTORDER123456"; // arbitrary value
	logic sys_clk, reset_n, reg_rd, reg_wr, reg_ack_ff;
	logic [15:0] reg_addr, reg_wdata, reg_rdata_ff, tmp;
	logic [2:0] reg_sub;
	logic [31:0] pv;
	logic [3:0] fault;
	logic [7:0] ev;
	logic act, app, abt, flg;
	logic [15:0] ida [7] = '{16'h0172, 16'h0173, 16'h0174, 16'h0175, 16'h0176, 16'h0177, 16'h017D};
	logic [15:0] ide [7] = '{ID_H, ID_L, ID_S, OEM_H, OEM_L, SW_D, NVM};
	int n_errors = 0;
	int total_checks = 0;
	int cyc = 0;

	mib_field_master m (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_sub(reg_sub),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rdata_ff(reg_rdata_ff), .reg_ack_ff(reg_ack_ff));
	// short hour and small limits keep the run near two thousand cycles
	mib_register_bank #(.HOUR_CYCLES(64'd1000), .PERIOD_HOURS_LIMIT(32'd2),
		.PERIOD_CYCLES_LIMIT(32'd3), .IDENT_HIGH(ID_H), .IDENT_LOW(ID_L),
		.IDENT_SERIAL(ID_S), .OEM_HIGH(OEM_H), .OEM_LOW(OEM_L), .SW_DIGITS(SW_D),
		.NVM_VERSION(NVM), .ORDER_TEXT(TXT)) uut (.sys_clk(sys_clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_sub(reg_sub), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_ack_ff(reg_ack_ff),
		.process_value_in(pv), .process_valid(ev[1]), .temp_sample(tmp),
		.temp_valid(ev[2]), .selftest_fault(fault), .diag_ack(ev[3]),
		.hours_limit_ack(ev[4]), .cycles_limit_ack(ev[5]), .panel_edit(ev[0]),
		.output_one(ev[6]), .output_two(ev[7]), .config_active_ff(act),
		.config_apply_ff(app), .config_abort_ff(abt), .panel_change_flag_ff(flg));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (reset_n)
			cyc <= cyc + 1;
	end

	// ----------------------------------------------------------------
	// access and compare tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		logic [15:0] q;
		m.xfer(1'b1, a, 3'h0, d, q);
	endtask : wr
	task automatic rd16(input logic [15:0] a, input logic [15:0] e, input logic [2:0] s = 0);
		logic [15:0] q;
		m.xfer(1'b0, a, s, 16'h0000, q);
		chk($sformatf("reg %h", a), {16'h0000, e}, {16'h0000, q});
	endtask : rd16
	task automatic rd32(input logic [15:0] a, input logic [31:0] e);
		logic [15:0] hi, lo;
		m.xfer(1'b0, a, 3'h0, 16'h0000, hi);
		m.xfer(1'b0, a, 3'h1, 16'h0000, lo);
		chk($sformatf("long %h", a), e, {hi, lo});
	endtask : rd32
	task automatic pulse(input int b, input int len);
		@(posedge sys_clk) ev[b] <= 1'b1;
		repeat (len) @(posedge sys_clk);
		ev[b] <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask : pulse
	task automatic upto(input int c);
		while (cyc < c) @(posedge sys_clk);
	endtask : upto
	task complete_run;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (5000) @(posedge sys_clk);
		n_errors++;
		complete_run;
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		ev = 8'h00;
		fault = 4'h0;
		pv = 32'h0000_0000;
		tmp = 16'h0000;
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		rd16(16'h0100, 16'h0000);
		rd16(16'h017E, 16'h0000);
		rd16(16'h017C, 16'h8000);
		rd32(16'h0186, 32'h0000_0000);
		for (int i = 0; i < 7; i++)
			rd16(ida[i], ide[i]);
		rd16(16'h0168, 16'h5445, 3'h0);
		rd16(16'h0168, 16'h3600, 3'h7);
		rd16(16'h0200, 16'h0000);
		wr(16'h0172, 16'hFFFF);
		rd16(16'h0172, ID_H);
		wr(16'h0100, 16'h0001);
		chk("active", 1, {31'h0, act});
		wr(16'h0100, 16'h0003);
		rd16(16'h0100, 16'h0001);
		wr(16'h0100, 16'h0000);
		chk("apply", 1, {31'h0, app});
		wr(16'h0100, 16'h0001);
		wr(16'h0100, 16'h0002);
		chk("abort", 1, {31'h0, abt});
		chk("active", 0, {31'h0, act});
		pulse(0, 1);
		rd16(16'h0101, 16'h0001);
		wr(16'h0101, 16'h0000);
		chk("flag", 0, {31'h0, flg});
		pv <= 32'd100;
		pulse(1, 1);
		pv <= 32'hFFFF_FFFB;
		pulse(1, 1);
		pv <= 32'd50;
		pulse(1, 1);
		rd32(16'h002B, 32'd100);
		rd32(16'h002A, 32'hFFFF_FFFB);
		rd32(16'h0027, 32'd50);
		wr(16'h0042, 16'h0001);
		rd32(16'h002B, 32'd50);
		wr(16'h0041, 16'h0001);
		rd32(16'h002A, 32'd50);
		tmp <= 16'h0030;
		pulse(2, 1);
		tmp <= 16'h0010;
		pulse(2, 1);
		rd16(16'h017C, 16'h0030);
		@(posedge sys_clk) fault <= 4'h5;
		@(posedge sys_clk) fault <= 4'h0;
		rd16(16'h017E, 16'h0005);
		pulse(3, 1);
		rd16(16'h017E, 16'h0000);
		repeat (3) pulse(6, 3);
		pulse(7, 3);
		rd32(16'h0187, 32'd0);
		rd16(16'h017E, 16'h0020);
		upto(1050);
		rd32(16'h0186, 32'd1);
		rd32(16'h0187, 32'd3);
		rd32(16'h0188, 32'd1);
		wr(16'h018C, 16'h0000);
		rd32(16'h018C, 32'd0);
		rd32(16'h018B, 32'd3);
		pulse(5, 1);
		rd32(16'h018B, 32'd0);
		rd32(16'h018C, 32'd0);
		rd16(16'h017E, 16'h0000);
		rd16(16'h0186, 16'h0000);
		upto(2050);
		rd16(16'h0186, 16'h0001, 3'h1);
		rd32(16'h018A, 32'd2);
		rd16(16'h017E, 16'h0010);
		pulse(4, 1);
		rd32(16'h018A, 32'd0);
		rd16(16'h017E, 16'h0000);
		rd32(16'h0186, 32'd2);
		complete_run;
	end
endmodule : test_maintenance_ident_register_bank

`default_nettype wire
